// ### src/hmac_unit.sv
// Memory-mapped 16x16 multiplier with two banks of 48-bit accumulator, on an APB slave.
// Assumes an APB master on clk_sys; every access answers after one wait state.
//
// Behaviour
// - Accumulate adds or subtracts product; otherwise store product or its negation.
// - Write-block set keeps accumulator; clear writes product, its negation, or acc plus/minus product into it.
// - Result pair holds product or its negation, acc plus/minus product, or acc plus/minus twice.
// - Unsigned accumulate/subtract overflows on carry or borrow at top bit.
// - Signed overflow when carry into sign differs from carry out.
// - Multiply and negate clear overflow; unsigned negate sets it.
// - Two-operand mode needs both operands; single mode starts on either.
// - Rewriting the already loaded operand does not start the operation.
// - Square mode loads both operands from one write and starts.
// - Clear bit zeroes operands, the selected bank's accumulator, overflow, counter; self-clears.
// - Operation completes one cycle after the last operand write.
// - Accumulator update waits one cycle and never blocks the next start.
// - Back-to-back operations need no wait states between loads.
// - Operand writes in any order and rate are tracked until complete.
// - Overflow flag is read-only, reset to zero, rewritten on each start.
// - Data-type bit selects signed two's-complement or unsigned arithmetic.
// - Two accumulator sets exist, chosen by a one-bit bank select.
// - Shift commands touch only the accumulator and shift carry, never the result pair.
// - Result pair holds until the next operation start or a clear.
// - Accumulator is high, mid and low words; top bit is sign.
// - Control write resets operand counter, keeps operands unless clearing.
// - Signed products are sign-extended to accumulator width.
// - Shifts keep sign or insert zero, carry out old end bit, self-clear.
`include "hmac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hmac_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Product widened to the accumulator.
    function automatic logic [47:0] ext_product(input logic [15:0] x, input logic [15:0] y,
                                                input logic uns);
        logic [31:0] p;
        p = uns ? x * y : 32'($signed(x) * $signed(y));
        ext_product = uns ? {16'h0000, p} : {{16{p[31]}}, p};
    endfunction : ext_product

    function automatic hmac_pkg::hmac_op_type decode_op(input logic acc_en, input logic neg);
        decode_op = hmac_pkg::hmac_op_type'({neg, acc_en});
    endfunction : decode_op

    // ****************************************************************
    // State
    // ****************************************************************
    logic [6:0] ctl_q;
    logic of_q;
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic have_a_q;
    logic have_b_q;
    logic start_q;
    logic [47:0] acc_q [2];
    logic bank_q;
    logic shc_q;
    logic [31:0] result_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [3:0] idx;
    logic mapped;
    logic access;
    logic wr_en;
    logic ctl_wr;
    logic clear_wr;
    logic opa_wr;
    logic opb_wr;
    logic shift_wr;
    logic trigger;

    assign idx = paddr[5:2];
    assign mapped = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) &&
        (idx inside {`HMAC_IDX_CONTROL, `HMAC_IDX_OPERAND_A, `HMAC_IDX_OPERAND_B,
                     `HMAC_IDX_ACCUM_HIGH, `HMAC_IDX_ACCUM_MID, `HMAC_IDX_ACCUM_LOW,
                     `HMAC_IDX_SHIFT, `HMAC_IDX_RESULT_UPPER, `HMAC_IDX_RESULT_LOWER,
                     `HMAC_IDX_BANK_SELECT});
    // Writes take effect only on the edge where the master sees pready.
    assign access = psel && penable && pready_q;
    assign wr_en = access && pwrite && mapped;
    assign ctl_wr = wr_en && (idx == `HMAC_IDX_CONTROL);
    assign clear_wr = ctl_wr && pwdata[`HMAC_CTL_CLEAR];
    assign opa_wr = wr_en && (idx == `HMAC_IDX_OPERAND_A);
    assign opb_wr = wr_en && (idx == `HMAC_IDX_OPERAND_B);
    assign shift_wr = wr_en && (idx == `HMAC_IDX_SHIFT);

    assign trigger = (opa_wr && (ctl_q[`HMAC_CTL_SQUARE] || ctl_q[`HMAC_CTL_SINGLE_OP]
                                 || have_b_q))
        || (opb_wr && (ctl_q[`HMAC_CTL_SQUARE] || ctl_q[`HMAC_CTL_SINGLE_OP] || have_a_q));

    // ****************************************************************
    // Datapath
    // ****************************************************************
    hmac_pkg::hmac_op_type op;
    logic sub;
    logic uns;
    logic [47:0] acc_cur;
    logic [47:0] prod;
    logic [47:0] addend;
    logic [48:0] sum49;
    logic [47:0] sum2;
    logic [47:0] acc_new;
    logic carry_top;
    logic carry_sign;
    logic ovf;

    assign op = decode_op(ctl_q[`HMAC_CTL_ACCUMULATE], ctl_q[`HMAC_CTL_NEG_SUB]);
    assign sub = ctl_q[`HMAC_CTL_NEG_SUB];
    assign uns = ctl_q[`HMAC_CTL_UNSIGNED];
    assign acc_cur = acc_q[bank_q];
    assign prod = ext_product(opa_q, opb_q, uns);
    // Subtraction is an add of the complement so one adder yields both carries.
    assign addend = sub ? ~prod : prod;
    assign sum49 = {1'b0, acc_cur} + {1'b0, addend} + {48'h0, sub};
    assign carry_top = sum49[48];
    assign carry_sign = sum49[47] ^ acc_cur[47] ^ addend[47];
    assign sum2 = sub ? sum49[47:0] - prod : sum49[47:0] + prod;

    always_comb
    begin
        acc_new = prod;
        ovf = 1'b0;
        unique case (op)
            hmac_pkg::HMAC_OP_MULTIPLY:
            begin
                acc_new = prod;
                ovf = 1'b0;
            end
            hmac_pkg::HMAC_OP_NEGATE:
            begin
                acc_new = 48'h0 - prod;
                ovf = uns;
            end
            hmac_pkg::HMAC_OP_MAC,
            hmac_pkg::HMAC_OP_NEGATE_OR_SUBTRACT:
            begin
                acc_new = sum49[47:0];
                ovf = uns ? (carry_top ^ sub) : (carry_top ^ carry_sign);
            end
        endcase
    end

    // ****************************************************************
    // Control register and overflow flag
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctl_q <= `HMAC_RST_CONTROL;
        end
        else if (ctl_wr)
        begin
            ctl_q <= {pwdata[`HMAC_CTL_WRITE_BLOCK], 1'b0, pwdata[4:0]};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            of_q <= 1'b0;
        end
        else if (start_q)
        begin
            of_q <= ovf;
        end
        else if (clear_wr)
        begin
            of_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Operands and load tracking
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            opa_q <= `HMAC_RST_DATA16;
            opb_q <= `HMAC_RST_DATA16;
        end
        else if (clear_wr)
        begin
            opa_q <= `HMAC_RST_DATA16;
            opb_q <= `HMAC_RST_DATA16;
        end
        else if (opa_wr || opb_wr)
        begin
            if (opa_wr || ctl_q[`HMAC_CTL_SQUARE])
            begin
                opa_q <= pwdata[15:0];
            end
            if (opb_wr || ctl_q[`HMAC_CTL_SQUARE])
            begin
                opb_q <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || ctl_wr || trigger)
        begin
            have_a_q <= 1'b0;
            have_b_q <= 1'b0;
        end
        else
        begin
            have_a_q <= have_a_q || opa_wr;
            have_b_q <= have_b_q || opb_wr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= trigger;
        end
    end

    // ****************************************************************
    // Result pair
    // ****************************************************************
    // result holds
    always_ff @(posedge clk_sys)
    begin
        if (rst || clear_wr)
        begin
            result_q <= `HMAC_RST_RESULT;
        end
        else if (start_q)
        begin
            if (ctl_q[`HMAC_CTL_ACCUMULATE] && !ctl_q[`HMAC_CTL_WRITE_BLOCK])
            begin
                result_q <= sum2[31:0];
            end
            else
            begin
                result_q <= acc_new[31:0];
            end
        end
    end

    // ****************************************************************
    // Accumulator banks and shifts
    // ****************************************************************
    // two banks
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            acc_q[0] <= `HMAC_RST_ACCUM;
            acc_q[1] <= `HMAC_RST_ACCUM;
        end
        else if (clear_wr)
        begin
            acc_q[bank_q] <= `HMAC_RST_ACCUM;
        end
        else if (start_q)
        begin
            if (!ctl_q[`HMAC_CTL_WRITE_BLOCK])
            begin
                acc_q[bank_q] <= acc_new;
            end
        end
        else if (wr_en)
        begin
            if (idx == `HMAC_IDX_ACCUM_HIGH)
            begin
                acc_q[bank_q][47:32] <= pwdata[15:0];
            end
            if (idx == `HMAC_IDX_ACCUM_MID)
            begin
                acc_q[bank_q][31:16] <= pwdata[15:0];
            end
            if (idx == `HMAC_IDX_ACCUM_LOW)
            begin
                acc_q[bank_q][15:0] <= pwdata[15:0];
            end
            if (shift_wr && pwdata[`HMAC_SHF_RIGHT])
            begin
                acc_q[bank_q] <= {acc_cur[47], acc_cur[47:1]};
            end
            else if (shift_wr && pwdata[`HMAC_SHF_LEFT])
            begin
                acc_q[bank_q] <= {acc_cur[46:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shc_q <= 1'b0;
        end
        else if (shift_wr)
        begin
            if (pwdata[`HMAC_SHF_RIGHT])
            begin
                shc_q <= acc_cur[0];
            end
            else if (pwdata[`HMAC_SHF_LEFT])
            begin
                shc_q <= acc_cur[47];
            end
            else
            begin
                shc_q <= shc_q && pwdata[`HMAC_SHF_CARRY];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bank_q <= 1'b0;
        end
        else if (wr_en && (idx == `HMAC_IDX_BANK_SELECT))
        begin
            bank_q <= pwdata[0];
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    // One wait state keeps read data registered and outputs straight from flops.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q <= 32'h0000_0000;
            if (psel && penable && !pready_q && !pwrite)
            begin
                unique case (idx)
                    `HMAC_IDX_CONTROL: prdata_q <= {24'h0, of_q, ctl_q};
                    `HMAC_IDX_OPERAND_A: prdata_q <= {16'h0, opa_q};
                    `HMAC_IDX_OPERAND_B: prdata_q <= {16'h0, opb_q};
                    `HMAC_IDX_ACCUM_HIGH: prdata_q <= {16'h0, acc_cur[47:32]};
                    `HMAC_IDX_ACCUM_MID: prdata_q <= {16'h0, acc_cur[31:16]};
                    `HMAC_IDX_ACCUM_LOW: prdata_q <= {16'h0, acc_cur[15:0]};
                    `HMAC_IDX_SHIFT: prdata_q <= {24'h0, shc_q, 7'h00};
                    `HMAC_IDX_RESULT_UPPER: prdata_q <= {16'h0, result_q[31:16]};
                    `HMAC_IDX_RESULT_LOWER: prdata_q <= {16'h0, result_q[15:0]};
                    `HMAC_IDX_BANK_SELECT: prdata_q <= {31'h0, bank_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_single_load;
        (opa_wr || opb_wr) && (ctl_q[`HMAC_CTL_SINGLE_OP] || ctl_q[`HMAC_CTL_SQUARE]);
    endsequence

    sequence s_first_of_two;
        opa_wr && !have_b_q && !ctl_q[`HMAC_CTL_SINGLE_OP] && !ctl_q[`HMAC_CTL_SQUARE];
    endsequence

    a_single_start: assert property (s_single_load |=> start_q)
        else $error("single operand write did not start an operation");
    a_two_wait: assert property (s_first_of_two |=> !start_q)
        else $error("first of two operands started an operation");
    a_negate_flag: assert property (start_q && op == hmac_pkg::HMAC_OP_NEGATE && uns
        |=> of_q)
        else $error("unsigned negate did not set overflow");
    a_mul_flag: assert property (start_q && op == hmac_pkg::HMAC_OP_MULTIPLY |=> !of_q)
        else $error("multiply left overflow set");
    a_result_hold: assert property (!start_q && !clear_wr |=> $stable(result_q))
        else $error("result pair changed without an operation");
    a_block_keep: assert property (start_q && ctl_q[`HMAC_CTL_WRITE_BLOCK]
        |=> acc_q[bank_q] == $past(acc_cur))
        else $error("write block did not preserve accumulator");
    a_clear_all: assert property (clear_wr |=> acc_cur == 48'h0 && !of_q && opa_q == 16'h0
        && !have_a_q && !ctl_q[`HMAC_CTL_CLEAR])
        else $error("clear did not zero the data");
    a_shift_left: assert property (shift_wr && pwdata[1:0] == 2'b01 && !start_q
        |=> acc_cur == {$past(acc_cur[46:0]), 1'b0} && shc_q == $past(acc_cur[47]))
        else $error("left shift wrong");
    a_apb_answer: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("APB answer not after one wait state");
    a_mac_store: assert property (start_q && op == hmac_pkg::HMAC_OP_MAC
        && !ctl_q[`HMAC_CTL_WRITE_BLOCK] |=> acc_cur == $past(acc_cur) + $past(prod))
        else $error("accumulate stored wrong value");

endmodule : hmac_unit

`default_nettype wire

// ### src/hmac_cfg.svh
// Register indices, field positions and reset values of the multiply-accumulate unit.
// Assumes a 32-bit APB slave where the byte address is four times the register index.
`ifndef HMAC_CFG_SVH
`define HMAC_CFG_SVH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define HMAC_IDX_CONTROL 4'h0
`define HMAC_IDX_OPERAND_A 4'h1
`define HMAC_IDX_OPERAND_B 4'h2
`define HMAC_IDX_ACCUM_HIGH 4'h3
`define HMAC_IDX_ACCUM_MID 4'h4
`define HMAC_IDX_ACCUM_LOW 4'h5
`define HMAC_IDX_SHIFT 4'h7
`define HMAC_IDX_RESULT_UPPER 4'h8
`define HMAC_IDX_RESULT_LOWER 4'h9
`define HMAC_IDX_BANK_SELECT 4'he

// ****************************************************************
// Control register fields
// ****************************************************************
`define HMAC_CTL_UNSIGNED 0
`define HMAC_CTL_ACCUMULATE 1
`define HMAC_CTL_NEG_SUB 2
`define HMAC_CTL_SINGLE_OP 3
`define HMAC_CTL_SQUARE 4
`define HMAC_CTL_CLEAR 5
`define HMAC_CTL_WRITE_BLOCK 6
`define HMAC_CTL_OVERFLOW 7

// ****************************************************************
// Shift register fields
// ****************************************************************
`define HMAC_SHF_LEFT 0
`define HMAC_SHF_RIGHT 1
`define HMAC_SHF_CARRY 7

// ****************************************************************
// Reset values
// ****************************************************************
`define HMAC_RST_CONTROL 7'h00
`define HMAC_RST_DATA16 16'h0000
`define HMAC_RST_ACCUM 48'h0000_0000_0000
`define HMAC_RST_RESULT 32'h0000_0000

`endif

// ### src/hmac_pkg.sv
// Types shared by the multiply-accumulate unit.
// Assumes nothing beyond a SystemVerilog elaborator.
package hmac_pkg;

    // Operation chosen by the accumulate and negate/subtract control bits.
    typedef enum logic [1:0] {
        HMAC_OP_MULTIPLY = 2'b00,
        HMAC_OP_MAC = 2'b01,
        HMAC_OP_NEGATE = 2'b10,
        HMAC_OP_NEGATE_OR_SUBTRACT = 2'b11
    } hmac_op_type;

endpackage : hmac_pkg

// ### bench/tb.sv
// Self-checking bench for the multiply-accumulate unit, driven over APB.
// Assumes hmac_unit answers every access after one wait state, on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_sys;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int errors;
    int check_count;
    int seed;
    logic [31:0] q;
    logic err;
    logic [80:0] e;
    logic [47:0] acc;
    logic [47:0] v;
    logic [15:0] a;
    logic [15:0] b;
    logic [2:0] m;
    logic wb;

    hmac_unit hmac_unit_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Bus, compare and model helpers
    // ****************************************************************
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            errors++;
            $display("[ERR] pready expected 1 seen %b", pready);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_acc(input logic [47:0] x);
        apb(1'b1, 4'h3, {16'h0, x[47:32]});
        apb(1'b1, 4'h4, {16'h0, x[31:16]});
        apb(1'b1, 4'h5, {16'h0, x[15:0]});
    endtask : wr_acc

    task automatic rd_acc(output logic [47:0] x);
        apb(1'b0, 4'h3, 32'h0);
        x[47:32] = q[15:0];
        apb(1'b0, 4'h4, 32'h0);
        x[31:16] = q[15:0];
        apb(1'b0, 4'h5, 32'h0);
        x[15:0] = q[15:0];
    endtask : rd_acc

    task automatic rd_res(output logic [47:0] x);
        apb(1'b0, 4'h8, 32'h0);
        x = {16'h0, q[15:0], 16'h0};
        apb(1'b0, 4'h9, 32'h0);
        x[15:0] = q[15:0];
    endtask : rd_res

    // Returns {overflow, new accumulator, result pair}; m is {neg_sub, accumulate, unsigned}.
    function automatic logic [80:0] model(input logic [2:0] m, input logic wb,
        input logic [47:0] acc, input logic [15:0] a, input logic [15:0] b);
        logic [31:0] pu;
        logic signed [31:0] ps;
        logic [47:0] p;
        logic [48:0] r;
        logic [47:0] r2;
        logic of;
        pu = a * b;
        ps = $signed(a) * $signed(b);
        p = m[0] ? {16'h0, pu} : {{16{ps[31]}}, ps};
        if (m[1])
        begin
            r = m[2] ? {1'b0, acc} - {1'b0, p} : {1'b0, acc} + {1'b0, p};
            r2 = m[2] ? acc - (p << 1) : acc + (p << 1);
            of = m[0] ? r[48] : ((acc[47] ^ p[47]) == m[2]) && (r[47] != acc[47]);
        end
        else
        begin
            r = m[2] ? {1'b0, -p} : {1'b0, p};
            r2 = r[47:0];
            of = m[2] & m[0];
        end
        return {of, wb ? acc : r[47:0], (m[1] && !wb) ? r2[31:0] : r[31:0]};
    endfunction : model

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        seed = 32'hb4e9daca;
        errors = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, 4'h0, 32'h0);
        chk("control", 48'h0, {16'h0, q});
        rd_acc(v);
        chk("accum", 48'h0, v);
        for (int i = 0; i < 32; i++)
        begin
            m = i[2:0];
            wb = i[3];
            a = 16'($random(seed));
            b = 16'($random(seed));
            acc[47:16] = $random(seed);
            acc[15:0] = 16'($random(seed));
            if (i[4])
            begin
                a = 16'h8000;
                b = 16'h8000;
                acc = m[2] ? {m[0] ? 16'h0 : 16'h8000, 32'h0}
                    : {m[0] ? 16'hffff : 16'h7fff, 32'hffffffff};
            end
            e = model(m, wb, acc, a, b);
            apb(1'b1, 4'h0, {25'h0, wb, 3'b000, m});
            wr_acc(acc);
            apb(1'b1, 4'h1, {16'h0, a});
            apb(1'b1, 4'h2, {16'h0, b});
            apb(1'b0, 4'h0, 32'h0);
            chk("control", {40'h0, e[80], wb, 3'b000, m}, {16'h0, q});
            if (m != 3'b101)
            begin
                rd_res(v);
                chk("result", {16'h0, e[31:0]}, v);
                rd_acc(v);
                chk("accum", e[79:32], v);
            end
        end
        a = 16'($random(seed));
        b = 16'($random(seed));
        apb(1'b1, 4'h0, 32'h60);
        apb(1'b1, 4'h1, {16'h0, a});
        apb(1'b1, 4'h1, {16'h0, b});
        rd_res(v);
        chk("result", 48'h0, v);
        apb(1'b1, 4'h2, {16'h0, a});
        e = model(3'b000, 1'b1, 48'h0, b, a);
        rd_res(v);
        chk("result", {16'h0, e[31:0]}, v);
        apb(1'b1, 4'h0, 32'h49);
        apb(1'b1, 4'h1, {16'h0, a});
        e = model(3'b001, 1'b1, 48'h0, a, a);
        rd_res(v);
        chk("result", {16'h0, e[31:0]}, v);
        apb(1'b1, 4'h0, 32'h20);
        apb(1'b0, 4'h0, 32'h0);
        chk("control", 48'h0, {16'h0, q});
        apb(1'b0, 4'h1, 32'h0);
        chk("operand_a", 48'h0, {16'h0, q});
        apb(1'b1, 4'h0, 32'h0a);
        apb(1'b1, 4'h2, {16'h0, b});
        apb(1'b1, 4'h1, {16'h0, a});
        apb(1'b1, 4'h1, {16'h0, b});
        e = model(3'b010, 1'b0, 48'h0, a, b);
        e = model(3'b010, 1'b0, e[79:32], b, b);
        rd_acc(v);
        chk("accum", e[79:32], v);
        rd_res(v);
        chk("result", {16'h0, e[31:0]}, v);
        acc[47:16] = $random(seed);
        acc[15:0] = 16'($random(seed));
        apb(1'b1, 4'h0, 32'h50);
        wr_acc(acc);
        apb(1'b1, 4'h1, {16'h0, a});
        apb(1'b0, 4'h2, 32'h0);
        chk("operand_b", {32'h0, a}, {16'h0, q});
        e = model(3'b000, 1'b1, acc, a, a);
        apb(1'b1, 4'h7, 32'h82);
        apb(1'b1, 4'h8, 32'hffff);
        rd_res(v);
        chk("result", {16'h0, e[31:0]}, v);
        rd_acc(v);
        chk("accum", {acc[47], acc[47:1]}, v);
        apb(1'b0, 4'h7, 32'h0);
        chk("shift", {40'h0, acc[0], 7'h0}, {16'h0, q});
        apb(1'b1, 4'h7, 32'h81);
        rd_acc(v);
        chk("accum", {acc[47:1], 1'b0}, v);
        apb(1'b1, 4'he, 32'h1);
        rd_acc(v);
        chk("accum", 48'h0, v);
        wr_acc({a, b, a});
        apb(1'b1, 4'he, 32'h0);
        rd_acc(v);
        chk("accum", {acc[47:1], 1'b0}, v);
        apb(1'b0, 4'h6, 32'h0);
        chk("slverr", 48'h1, {47'h0, err});
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
endmodule : tb

`default_nettype wire
